//--- hdl/mav_pkg.sv
`default_nettype none
package mav_pkg;
  // widths
  localparam int ADDR_W = 24;
  localparam int KIND_W = 4;
  localparam int CLS_W = 4;
  localparam int CCR_W = 16;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 32;
  localparam int AVS_AW = 10;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam int NMST = 3;
  localparam int NRGN = 8;
  localparam int NMAP = 7;

  // master slots
  localparam int M_CPU = 0;
  localparam int M_BDC = 1;
  localparam int M_ADC = 2;

  // one-hot region bit positions
  localparam int RB_REG = 0;
  localparam int RB_RAM = 1;
  localparam int RB_EEP = 2;
  localparam int RB_RSV = 3;
  localparam int RB_RO = 4;
  localparam int RB_IFR = 5;
  localparam int RB_PNVM = 6;
  localparam int RB_UNMAP = 7;

  // mapped windows, inclusive, indexed by region bit; plain defaults
  localparam logic [ADDR_W-1:0] MAP_LO [NMAP] = '{
    24'h000000, 24'h001000, 24'h100000, 24'h002000,
    24'h1F0000, 24'h1F4000, 24'hFF8000};
  localparam logic [ADDR_W-1:0] MAP_HI [NMAP] = '{
    24'h000FFF, 24'h0013FF, 24'h10007F, 24'h0FFFFF,
    24'h1F3FFF, 24'h1F7FFF, 24'hFFFFFF};

  // access kind codes
  localparam logic [KIND_W-1:0] ACC_NONE = 4'h0;
  localparam logic [KIND_W-1:0] ACC_FETCH = 4'h1;
  localparam logic [KIND_W-1:0] ACC_VECT = 4'h2;
  localparam logic [KIND_W-1:0] ACC_LOAD = 4'h3;
  localparam logic [KIND_W-1:0] ACC_STORE = 4'h4;

  // violation class codes
  localparam logic [CLS_W-1:0] CLS_NONE = 4'h0;
  localparam logic [CLS_W-1:0] CLS_ILLADDR = 4'h1;
  localparam logic [CLS_W-1:0] CLS_ECC = 4'h2;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ECODE = 8'h80;
  localparam logic [IDX_W-1:0] IDX_CCRH = 8'h82;
  localparam logic [IDX_W-1:0] IDX_CCRL = 8'h83;
  localparam logic [IDX_W-1:0] IDX_PC = 8'h84;
  localparam logic [IDX_W-1:0] IDX_STS = 8'h88;
  localparam logic [IDX_W-1:0] IDX_MSK = 8'h89;
  localparam logic [CCR_W-1:0] ECODE_CLEAR = 16'hFFFF;

  // event status bits
  localparam int STS_W = 4;
  localparam int SB_CAPT = 0;
  localparam int SB_CPU = 1;
  localparam int SB_BDC = 2;
  localparam int SB_ADC = 3;
endpackage
`default_nettype wire

//--- hdl/mav_region_decode.sv
`timescale 1ns/1ns
`default_nettype none
module mav_region_decode
  import mav_pkg::*;
(
  // access address
  input wire logic [ADDR_W-1:0] addr,
  // one-hot region
  output logic [NRGN-1:0] region
);
  logic [NMAP-1:0] hit;

  // window compare per mapped region
  for (genvar i = 0; i < NMAP; i++) begin : g_win
    assign hit[i] = (addr >= MAP_LO[i]) && (addr <= MAP_HI[i]);
  end

  // lowest window wins, no hit means unmapped
  always_comb begin
    region = '0;
    for (int i = NMAP - 1; i >= 0; i--) begin
      if (hit[i]) begin
        region = '0;
        region[i] = 1'b1;
      end
    end
    region[RB_UNMAP] = ~|hit;
  end
endmodule // mav_region_decode
`default_nettype wire

//--- hdl/mav_perm_check.sv
`timescale 1ns/1ns
`default_nettype none
module mav_perm_check
  import mav_pkg::*;
#(
  parameter int MST = M_CPU
) (
  // access
  input wire logic valid,
  input wire logic [NRGN-1:0] region,
  input wire logic [KIND_W-1:0] kind,
  // mode and nvm state
  input wire logic ssMode,
  input wire logic nvmBusy,
  input wire logic nvmUnsup,
  // verdict
  output logic illegal
);
  logic isRd, isWr, isEx, rdBad, wrBad, exBad, col, isAdc, isCpu;

  // permission table by region and master
  always_comb begin
    isAdc = (MST == M_ADC);
    isCpu = (MST == M_CPU);
    isRd = (kind == ACC_LOAD) || (kind == ACC_VECT);
    isWr = (kind == ACC_STORE);
    isEx = (kind == ACC_FETCH);
    rdBad = region[RB_UNMAP] | (isAdc & (region[RB_REG] | region[RB_RSV]
          | region[RB_RO] | region[RB_IFR]));
    wrBad = region[RB_EEP] | region[RB_RO] | region[RB_IFR]
          | region[RB_PNVM] | region[RB_UNMAP];
    wrBad = wrBad | (isAdc & region[RB_REG]);
    wrBad = wrBad | (region[RB_RSV] & (isAdc | (isCpu & ~ssMode)));
    exBad = region[RB_REG] | region[RB_RSV] | region[RB_RO]
          | region[RB_IFR] | region[RB_UNMAP];
    col = nvmBusy & nvmUnsup & (region[RB_EEP] | region[RB_IFR]
        | region[RB_PNVM]);
    illegal = valid & ((isRd & rdBad) | (isWr & wrBad) | (isEx & exBad)
            | ((isRd | isWr | isEx) & col));
  end
endmodule // mav_perm_check
`default_nettype wire

//--- hdl/mav_capture.sv
// Function
// - The low error byte holds the access kind in bits 7-4: 0 none, 1 fetch, 2 vector, 3 load, 4 store.
// - The low error byte holds the violation class in bits 3-0: 0 none, 1 illegal address, 2 ECC.
// - A core violation or an uncorrectable ECC error loads a non-zero error code.
// - Program counter and condition flags are captured in the same cycle as the error code.
// - While the error code is non-zero, code, counter and flags are frozen.
// - Writing 0xFFFF to the error code clears it and re-arms capture.
// - Every access of every master is checked against the region and master table.
// - Reserved-space writes: core only in special single-chip mode, debug port always, converter never.
// - Writes to EEPROM, program NVM, info row, read-only and unmapped space, any unmapped access and fetches from register, reserved or info row space are illegal.
// - An unsupported NVM access while an NVM command runs is illegal.
// - Each illegal core access raises a machine exception.
// - Each illegal debug-port access sets the debug bad-access flag instead.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module mav_capture
  import mav_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [AVS_AW-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [DATA_W-1:0] avsWritedata,
  input wire logic [DATA_W/BYTE_W-1:0] avsByteenable,
  output logic [DATA_W-1:0] avsReaddata,
  output logic avsWaitrequest,
  // processor core access
  input wire logic cpuValid,
  input wire logic [ADDR_W-1:0] cpuAddr,
  input wire logic [KIND_W-1:0] cpuKind,
  input wire logic [ADDR_W-1:0] cpuPc,
  input wire logic [CCR_W-1:0] cpuCcr,
  input wire logic eccError,
  // debug port access
  input wire logic bdcValid,
  input wire logic [ADDR_W-1:0] bdcAddr,
  input wire logic [KIND_W-1:0] bdcKind,
  input wire logic bdcFlagClr,
  // converter access
  input wire logic adcValid,
  input wire logic [ADDR_W-1:0] adcAddr,
  input wire logic [KIND_W-1:0] adcKind,
  // mode and nvm state
  input wire logic ssMode,
  input wire logic nvmBusy,
  input wire logic nvmUnsup,
  // reports
  output logic cpuMachineExc,
  output logic debug_port_bad_access_flag,
  output logic irq
);
  typedef struct packed {
    logic [KIND_W-1:0] accKind;
    logic [CLS_W-1:0] errCls;
    logic [ADDR_W-1:0] pc;
    logic [CCR_W-1:0] ccr;
    logic [STS_W-1:0] sts;
    logic [STS_W-1:0] msk;
    logic exc;
    logic bdcFlag;
    logic irq;
    logic waitReq;
    logic [DATA_W-1:0] rdata;
  } mav_state_s;

  mav_state_s q, d;
  logic [NMST-1:0] mValid, ill;
  logic [ADDR_W-1:0] mAddr [NMST];
  logic [KIND_W-1:0] mKind [NMST];
  logic [NRGN-1:0] mRgn [NMST];
  logic [IDX_W-1:0] idx;
  logic req, take, clrWr, armed, capt;
  logic [BYTE_W-1:0] ecodeLow;

  // gather the three masters
  assign mValid[M_CPU] = cpuValid;
  assign mValid[M_BDC] = bdcValid;
  assign mValid[M_ADC] = adcValid;
  assign mAddr[M_CPU] = cpuAddr;
  assign mAddr[M_BDC] = bdcAddr;
  assign mAddr[M_ADC] = adcAddr;
  assign mKind[M_CPU] = cpuKind;
  assign mKind[M_BDC] = bdcKind;
  assign mKind[M_ADC] = adcKind;

  // decode and check each master's access
  for (genvar m = 0; m < NMST; m++) begin : g_mst
    mav_region_decode u_dec (
      .addr(mAddr[m]),
      .region(mRgn[m])
    );
    mav_perm_check #(.MST(m)) u_chk (
      .valid(mValid[m]),
      .region(mRgn[m]),
      .kind(mKind[m]),
      .ssMode(ssMode),
      .nvmBusy(nvmBusy),
      .nvmUnsup(nvmUnsup),
      .illegal(ill[m])
    );
  end

  // bus decode
  assign idx = avsAddress[AVS_AW-1:IDX_LSB];
  assign req = avsRead | avsWrite;
  assign take = req & ~q.waitReq;
  assign ecodeLow = {q.accKind, q.errCls};
  assign clrWr = take & avsWrite & (idx == IDX_ECODE)
               & (&avsByteenable[1:0])
               & (avsWritedata[CCR_W-1:0] == ECODE_CLEAR);

  // capture is armed while the code is zero or being cleared
  assign armed = (ecodeLow == '0) | clrWr;
  assign capt = armed & (ill[M_CPU] | eccError);

  // read mux
  function automatic logic [DATA_W-1:0] rdMux(input logic [IDX_W-1:0] i,
                                              input mav_state_s s);
    logic [DATA_W-1:0] v;
    v = '0;
    case (i)
      IDX_ECODE: v = DATA_W'({s.accKind, s.errCls});
      IDX_CCRH: v = DATA_W'(s.ccr[CCR_W-1:BYTE_W]);
      IDX_CCRL: v = DATA_W'(s.ccr[BYTE_W-1:0]);
      IDX_PC: v = DATA_W'(s.pc);
      IDX_STS: v = DATA_W'(s.sts);
      IDX_MSK: v = DATA_W'(s.msk);
      default: v = '0;
    endcase
    return v;
  endfunction

  // next-state logic
  always_comb begin
    d = q;
    // exception pulses once per illegal core access
    d.exc = ill[M_CPU];
    // debug flag: set wins over clear
    d.bdcFlag = (q.bdcFlag & ~bdcFlagClr) | ill[M_BDC];
    // error code clear
    if (clrWr) begin
      d.accKind = ACC_NONE;
      d.errCls = CLS_NONE;
    end
    // first violation capture, core violation before ecc
    if (capt) begin
      d.accKind = cpuKind;
      d.errCls = ill[M_CPU] ? CLS_ILLADDR : CLS_ECC;
      d.pc = cpuPc;
      d.ccr = cpuCcr;
    end
    // status write-one-to-clear and mask write
    if (take & avsWrite & avsByteenable[0]) begin
      if (idx == IDX_STS) begin
        d.sts = q.sts & ~avsWritedata[STS_W-1:0];
      end
      if (idx == IDX_MSK) begin
        d.msk = avsWritedata[STS_W-1:0];
      end
    end
    // events set after clear so set wins
    d.sts[SB_CAPT] = d.sts[SB_CAPT] | capt;
    d.sts[SB_CPU] = d.sts[SB_CPU] | ill[M_CPU];
    d.sts[SB_BDC] = d.sts[SB_BDC] | ill[M_BDC];
    d.sts[SB_ADC] = d.sts[SB_ADC] | ill[M_ADC];
    d.irq = |(d.sts & d.msk);
    // one wait cycle, then answer for one cycle
    d.waitReq = 1'b1;
    if (req & q.waitReq) begin
      d.waitReq = 1'b0;
      d.rdata = avsRead ? rdMux(idx, q) : '0;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.waitReq <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // outputs from flops
  assign avsReaddata = q.rdata;
  assign avsWaitrequest = q.waitReq;
  assign cpuMachineExc = q.exc;
  assign debug_port_bad_access_flag = q.bdcFlag;
  assign irq = q.irq;
endmodule // mav_capture
`default_nettype wire

//--- testbench/mav_capture_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module mav_capture_asserts
  import mav_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bus handshake
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitrequest,
  // accesses
  input wire logic cpuValid,
  input wire logic [ADDR_W-1:0] cpuAddr,
  input wire logic [KIND_W-1:0] cpuKind,
  input wire logic bdcValid,
  input wire logic [ADDR_W-1:0] bdcAddr,
  input wire logic [KIND_W-1:0] bdcKind,
  input wire logic bdcFlagClr,
  // reports
  input wire logic cpuMachineExc,
  input wire logic debug_port_bad_access_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // a bus request still waiting
  sequence s_req;
    (avsRead || avsWrite) && avsWaitrequest;
  endsequence
  // a core store into the eeprom window
  sequence s_eep_st;
    cpuValid && cpuKind == ACC_STORE && cpuAddr[23:7] == 17'h02000;
  endsequence
  chk_wait_one: assert property (s_req |=> !avsWaitrequest)
    else $error("bus answer missing");
  chk_wait_short: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("wait low too long");
  chk_exc_store: assert property (s_eep_st
    |=> cpuMachineExc) else $error("no exception on eeprom store");
  chk_exc_cause: assert property (cpuMachineExc |-> $past(cpuValid))
    else $error("exception without core access");
  chk_ram_ok: assert property (cpuValid && cpuAddr[23:10] == 14'h0004
    && cpuKind != ACC_NONE |=> !cpuMachineExc)
    else $error("exception on ram access");
  chk_flag_cause: assert property ($rose(debug_port_bad_access_flag)
    |-> $past(bdcValid)) else $error("flag without debug access");
  chk_flag_hold: assert property (debug_port_bad_access_flag
    && !bdcFlagClr |=> debug_port_bad_access_flag)
    else $error("flag dropped");
  chk_bdc_unmap: assert property (bdcValid && bdcKind == ACC_LOAD
    && bdcAddr[23:20] == 4'h3 |=> debug_port_bad_access_flag)
    else $error("no flag on unmapped read");
endmodule // mav_capture_asserts
bind mav_capture mav_capture_asserts i_chk (.core_clk(core_clk),
  .rstn(rstn), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsWaitrequest(avsWaitrequest), .cpuValid(cpuValid),
  .cpuAddr(cpuAddr), .cpuKind(cpuKind), .bdcValid(bdcValid),
  .bdcAddr(bdcAddr), .bdcKind(bdcKind), .bdcFlagClr(bdcFlagClr),
  .cpuMachineExc(cpuMachineExc),
  .debug_port_bad_access_flag(debug_port_bad_access_flag));
`default_nettype wire

//--- testbench/mav_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module mav_master_model
  import mav_pkg::*;
(
  // clock and command
  input wire logic core_clk,
  input wire logic go,
  input wire logic [1:0] mst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [KIND_W-1:0] kind,
  // access buses
  output logic [NMST-1:0] valid,
  output logic [ADDR_W-1:0] busAddr [NMST],
  output logic [KIND_W-1:0] busKind [NMST]
);
  // one access per command, idle lines flip every cycle
  initial busAddr = '{default: '0};
  initial busKind = '{default: '0};
  always @(posedge core_clk) begin
    for (int m = 0; m < NMST; m++) begin
      valid[m] <= go && mst == m;
      busAddr[m] <= (go && mst == m) ? addr : ~busAddr[m];
      busKind[m] <= (go && mst == m) ? kind : ~busKind[m];
    end
  end
endmodule // mav_master_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mav_pkg::*;
  logic core_clk = 0, rstn = 0, avsRead = 0, avsWrite = 0, go = 0;
  logic eccError = 0, bdcFlagClr = 0, ssMode = 0, nvmBusy = 0;
  logic nvmUnsup = 0, avsWaitrequest, cpuMachineExc, dFlag, irq, eFlag;
  logic [AVS_AW-1:0] avsAddress = '0;
  logic [DATA_W-1:0] avsWritedata = '0, avsReaddata, rd;
  logic [3:0] avsByteenable = 4'hF;
  logic [1:0] mst = '0;
  logic [ADDR_W-1:0] addr = '0, cpuPc = '0, pc;
  logic [KIND_W-1:0] kind = '0;
  logic [CCR_W-1:0] cpuCcr = '0, ccr, code;
  logic [NMST-1:0] valid;
  logic [ADDR_W-1:0] bA [NMST];
  logic [KIND_W-1:0] bK [NMST];
  logic [STS_W-1:0] sts, msk;
  int err_total = 0, samples_checked = 0;
  always #2 core_clk = ~core_clk;
  mav_master_model i_mav_master_model (.core_clk(core_clk), .go(go),
    .mst(mst), .addr(addr), .kind(kind), .valid(valid), .busAddr(bA),
    .busKind(bK));
  mav_capture i_mav_capture (.core_clk(core_clk), .rstn(rstn), .ce(1'b1),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .cpuValid(valid[M_CPU]), .cpuAddr(bA[M_CPU]), .cpuKind(bK[M_CPU]),
    .cpuPc(cpuPc), .cpuCcr(cpuCcr), .eccError(eccError),
    .bdcValid(valid[M_BDC]), .bdcAddr(bA[M_BDC]), .bdcKind(bK[M_BDC]),
    .bdcFlagClr(bdcFlagClr), .adcValid(valid[M_ADC]), .adcAddr(bA[M_ADC]),
    .adcKind(bK[M_ADC]), .ssMode(ssMode), .nvmBusy(nvmBusy),
    .nvmUnsup(nvmUnsup), .cpuMachineExc(cpuMachineExc),
    .debug_port_bad_access_flag(dFlag), .irq(irq));
  task automatic cmp(input string nm, input logic [DATA_W-1:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one register transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [IDX_W-1:0] ix,
    input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    avsAddress <= {ix, 2'b00};
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    // a missing answer shows up here as a failed check
    cmp("bus answer", 0, avsWaitrequest);
    rd = avsReaddata;
    avsRead <= 0;
    avsWrite <= 0;
  endtask
  // expected verdict from region, master and kind
  function automatic logic illeg(int m, logic [ADDR_W-1:0] a,
    logic [KIND_W-1:0] k);
    int r;
    logic w, f, col;
    r = RB_UNMAP;
    for (int i = NMAP - 1; i >= 0; i--)
      if (a >= MAP_LO[i] && a <= MAP_HI[i]) r = i;
    w = k == ACC_STORE;
    f = k == ACC_FETCH;
    col = nvmBusy && nvmUnsup;
    if (k == ACC_NONE || k > ACC_STORE) return 0;
    case (r)
      RB_REG: return f || m == M_ADC;
      RB_RAM: return 0;
      RB_EEP, RB_PNVM: return w || col;
      RB_RSV: return f || m == M_ADC || (w && m == M_CPU && !ssMode);
      RB_RO: return w || f || m == M_ADC;
      RB_IFR: return w || f || m == M_ADC || col;
      default: return 1;
    endcase
  endfunction
  // one access through the master model, then its reports
  task automatic acc(input int m, input logic [ADDR_W-1:0] a,
    input logic [KIND_W-1:0] k, input logic ecc);
    logic il, c;
    c = $urandom % 4 == 0;
    @(posedge core_clk);
    go <= 1;
    mst <= 2'(m);
    addr <= a;
    kind <= k;
    @(posedge core_clk);
    go <= 0;
    eccError <= ecc && m == M_CPU;
    bdcFlagClr <= c;
    cpuPc <= 24'($urandom);
    cpuCcr <= 16'($urandom);
    @(posedge core_clk);
    eccError <= 0;
    bdcFlagClr <= 0;
    #1;
    il = illeg(m, a, k);
    if (m == M_CPU && (il || ecc) && code == 0) begin
      code = {8'h00, k, il ? CLS_ILLADDR : CLS_ECC};
      pc = cpuPc;
      ccr = cpuCcr;
      sts[SB_CAPT] = 1;
    end
    if (il) sts[m + 1] = 1;
    eFlag = (m == M_BDC && il) || (eFlag && !c);
    cmp("exception", m == M_CPU && il, cpuMachineExc);
    cmp("bad access flag", eFlag, dFlag);
    cmp("irq", |(sts & msk), irq);
  endtask
  // captured registers and status
  task automatic regs;
    bus(0, IDX_ECODE, 0);
    cmp("error code", code, rd);
    bus(0, IDX_PC, 0);
    cmp("pc", pc, rd);
    bus(0, IDX_CCRH, 0);
    cmp("flags high", ccr[15:8], rd);
    bus(0, IDX_CCRL, 0);
    cmp("flags low", ccr[7:0], rd);
    bus(0, IDX_STS, 0);
    cmp("status", sts, rd);
  endtask
  // watchdog
  initial begin
    #60000;
    err_total++;
    final_report;
  end
  // main sequence
  initial begin
    int r, m;
    logic [ADDR_W-1:0] a;
    logic [KIND_W-1:0] k;
    void'($urandom(45390));
    {code, pc, ccr, sts, msk, eFlag} = '0;
    repeat (4) @(posedge core_clk);
    rstn <= 1;
    regs;
    bus(0, 8'h10, 0);
    cmp("unmapped read", 0, rd);
    $display("test reset done");
    for (int t = 0; t < 8; t++) begin
      msk = 4'($urandom);
      bus(1, IDX_MSK, {28'h0, msk});
      ssMode <= t[0];
      nvmBusy <= t[1];
      nvmUnsup <= t[1] & t[2];
      acc(M_CPU, MAP_LO[RB_RAM], ACC_LOAD, 1);
      repeat (30) begin
        r = $urandom % 8;
        a = r == 7 ? 24'h300000 + 24'($urandom % 65536)
          : MAP_LO[r] + 24'($urandom % 64);
        m = $urandom % 3;
        k = m == M_CPU ? 4'(1 + $urandom % 4) : 4'(3 + $urandom % 2);
        acc(m, a, k, $urandom % 8 == 0);
      end
      regs;
      bus(1, IDX_ECODE, 32'h0000_00FF);
      bus(0, IDX_ECODE, 0);
      cmp("error code kept", code, rd);
      bus(1, IDX_ECODE, 32'h0000_FFFF);
      code = 0;
      bus(0, IDX_ECODE, 0);
      cmp("error code cleared", code, rd);
      bus(1, IDX_STS, 32'h0000_000F);
      sts = 0;
      $display("test round %0d done", t);
    end
    final_report;
  end
endmodule // testbench
`default_nettype wire
